// [mesh_stop_event_select.v]
// Event selection and qualification for one mesh stop's performance counter.
// Assumes all event inputs come from logic on REF_CLK; EVENT_SEL is stable software state.
// What this block does
// - Code 0xb1 counts ingress allocations, qualified by ring type and class mask.
// - Code 0xb0 adds ingress occupancy every cycle for selected classes.
// - Ingress events observe only the ingress queue fed from the mesh.
// - Ingress allocation and occupancy with bounce and credit both set for one ring add both contributions.
// - Code 0xd0 counts request agent0 credit stall cycles per selected transgress.
// - Code 0xd2 counts request agent1 credit stall cycles per transgress.
// - Code 0xd4 counts data agent0 credit stall cycles per transgress.
// - Code 0xd6 counts data agent1 credit stall cycles per transgress.
// - Stall events use mask bits 0 to 5 for transgress 0 to 5.
// - Code 0x9d counts deadlock-slot packets; no snoop bounce class.
// - Code 0x9f counts horizontal egress bypass packets by ring and class.
// - Code 0x96 counts cycles selected horizontal buffers are full.
// - Code 0x97 counts cycles selected horizontal buffers are not empty.
// - Code 0x95 counts horizontal buffer allocations; snoop bounce is mask bit 3.
// - Full, not-empty and insert events observe the horizontal egress queue.
// - Code 0xb3 counts credit starvation cycles; top mask bit is extra-ack credit.
// - Starvation counts OR of classes; extra-ack credit counts as ack ring.
`timescale 1ns/1ps
`include "mesh_stop_event_defines.vh"
module mesh_stop_event_select #(
  parameter OCC_W = `OCC_WIDTH,
  parameter CNT_W = 48
) (
  input wire REF_CLK, // Uncore clock
  input wire SYS_RST, // Synchronous reset, active high
  input wire [15:0] EVENT_SEL, // [7:0] event code, [15:8] unit mask
  input wire [7:0] INGRESS_ALLOC, // Ingress allocation per class this cycle
  input wire [8*OCC_W-1:0] INGRESS_OCC, // Ingress occupancy per class
  input wire [7:0] INGRESS_STARVE, // Ingress credit starvation per class
  input wire [5:0] REQ_AG0_STALL, // Request agent0 stall, per transgress
  input wire [5:0] REQ_AG1_STALL, // Request agent1 stall, per transgress
  input wire [5:0] DATA_AG0_STALL, // Data agent0 stall, per transgress
  input wire [5:0] DATA_AG1_STALL, // Data agent1 stall, per transgress
  input wire [7:0] HORIZ_SLOT_USED, // Deadlock-slot use per class
  input wire [7:0] HORIZ_BYPASS, // Horizontal egress bypass per class
  input wire [7:0] HORIZ_FULL, // Horizontal buffer full per class
  input wire [7:0] HORIZ_NONEMPTY, // Horizontal buffer not empty per class
  input wire [7:0] HORIZ_ALLOC, // Horizontal buffer allocation per class
  input wire CNT_CLEAR, // Clears the event count
  output reg [CNT_W-1:0] EVENT_COUNT, // Accumulated event count
  output reg [8:0] EVENT_INC, // Increment applied last cycle
  output reg EVENT_HIT // Event qualified last cycle
);
  localparam IW = `INC_WIDTH;
  wire [7:0] code = EVENT_SEL[7:0];
  wire [7:0] umask = EVENT_SEL[15:8];

  // Single-bit class events widened so one summing module serves every event except the stall events
  function [8*OCC_W-1:0] widen;
    input [7:0] b;
    integer k;
    begin
      widen = {8*OCC_W{1'b0}};
      for (k = 0; k < 8; k = k + 1)
        widen[k*OCC_W] = b[k];
    end
  endfunction

  reg [8*OCC_W-1:0] vals;
  reg [7:0] sel;
  reg use_or;
  reg code_ok;
  reg is_stall;
  reg [5:0] stall_hits;
  wire [IW-1:0] sum;
  wire any;

  // Named class selects; mask bit 5 names no class in these events
  wire request_bounce_sel = umask[`UM_REQ_BNC];
  wire ack_bounce_sel = umask[`UM_ACK_BNC];
  wire data_bounce_sel = umask[`UM_DATA_BNC];
  wire snoop_bounce_sel = umask[`UM_SNOOP_BNC];
  wire request_credit_sel = umask[`UM_REQ_CRD];
  wire data_credit_sel = umask[`UM_DATA_CRD];
  wire extra_ack_credit_sel = umask[`UM_EXTRA_ACK_CRD];

  // Per-event class vectors built from the named selects
  reg [7:0] ring_cls;
  reg [7:0] slot_cls;
  reg [7:0] starve_cls;
  always @* begin
    ring_cls = 8'h00;
    ring_cls[`UM_REQ_BNC] = request_bounce_sel;
    ring_cls[`UM_ACK_BNC] = ack_bounce_sel;
    ring_cls[`UM_DATA_BNC] = data_bounce_sel;
    ring_cls[`UM_SNOOP_BNC] = snoop_bounce_sel;
    ring_cls[`UM_REQ_CRD] = request_credit_sel;
    ring_cls[`UM_DATA_CRD] = data_credit_sel;
    ring_cls = ring_cls & `UM_CLASS_MASK;
    // The anti-deadlock slot has no snoop-ring bounce class
    slot_cls = ring_cls & `UM_DEADLOCK_SLOT_MASK;
    // Extra-ack credit exists for starvation only and joins the ack ring there
    starve_cls = ring_cls;
    starve_cls[`UM_EXTRA_ACK_CRD] = extra_ack_credit_sel;
    starve_cls = starve_cls & `UM_STARVE_MASK;
  end

  always @* begin
    vals = {8*OCC_W{1'b0}};
    sel = 8'h00;
    use_or = 1'b0;
    code_ok = 1'b1;
    is_stall = 1'b0;
    stall_hits = 6'h00;
    case (code)
      `EVT_INGRESS_ALLOC: begin
        vals = widen(INGRESS_ALLOC);
        sel = ring_cls;
      end
      `EVT_INGRESS_OCCUPANCY: begin
        vals = INGRESS_OCC;
        sel = ring_cls;
      end
      `EVT_INGRESS_CREDIT_STARVE: begin
        vals = widen(INGRESS_STARVE);
        sel = starve_cls;
        use_or = 1'b1;
      end
      // Stall events ignore ring classes; mask bits 5:0 pick transgresses
      `EVT_REQ_AG0_STALL: begin
        is_stall = 1'b1;
        stall_hits = REQ_AG0_STALL & umask[5:0];
      end
      `EVT_REQ_AG1_STALL: begin
        is_stall = 1'b1;
        stall_hits = REQ_AG1_STALL & umask[5:0];
      end
      `EVT_DATA_AG0_STALL: begin
        is_stall = 1'b1;
        stall_hits = DATA_AG0_STALL & umask[5:0];
      end
      `EVT_DATA_AG1_STALL: begin
        is_stall = 1'b1;
        stall_hits = DATA_AG1_STALL & umask[5:0];
      end
      `EVT_HORIZ_DEADLOCK_SLOT: begin
        vals = widen(HORIZ_SLOT_USED);
        sel = slot_cls;
      end
      `EVT_HORIZ_BYPASS: begin
        vals = widen(HORIZ_BYPASS);
        sel = ring_cls;
      end
      `EVT_HORIZ_FULL: begin
        // Cycle event: one count per cycle however many classes are full
        vals = widen(HORIZ_FULL);
        sel = ring_cls;
        use_or = 1'b1;
      end
      `EVT_HORIZ_NONEMPTY: begin
        // Cycle event like full: at most one count per cycle
        vals = widen(HORIZ_NONEMPTY);
        sel = ring_cls;
        use_or = 1'b1;
      end
      `EVT_HORIZ_ALLOC: begin
        vals = widen(HORIZ_ALLOC);
        sel = ring_cls;
      end
      default: begin
        // Codes outside this block, vertical events included, count nothing
        code_ok = 1'b0;
      end
    endcase
  end

  // One shared summer; OR events read its any flag instead of the sum
  class_accum #(.N(8), .W(OCC_W), .OW(IW)) u_accum (
    .vals(vals),
    .sel(sel),
    .sum(sum),
    .any(any)
  );

  // One count per selected transgress in stall, so up to six per cycle
  function [IW-1:0] count_stalls;
    input [`NUM_TRANSGRESS-1:0] h;
    integer j;
    begin
      count_stalls = {IW{1'b0}};
      for (j = 0; j < `NUM_TRANSGRESS; j = j + 1)
        count_stalls = count_stalls + {{(IW-1){1'b0}}, h[j]};
    end
  endfunction

  reg [IW-1:0] nxt_inc;
  always @* begin
    // Stall, OR and sum paths are exclusive by event code
    nxt_inc = {IW{1'b0}};
    if (!code_ok) begin
      nxt_inc = {IW{1'b0}};
    end else if (is_stall) begin
      nxt_inc = count_stalls(stall_hits);
    end else if (use_or) begin
      nxt_inc = {{(IW-1){1'b0}}, any};
    end else begin
      // Both classes of one ring add up; several rings would sum as well
      nxt_inc = sum;
    end
  end

  // Clear beats a same-cycle increment, so a read after clear is a true zero
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      EVENT_COUNT <= {CNT_W{1'b0}};
      EVENT_INC <= 9'h000;
      EVENT_HIT <= 1'b0;
    end else begin
      EVENT_INC <= nxt_inc;
      EVENT_HIT <= |nxt_inc;
      if (CNT_CLEAR)
        EVENT_COUNT <= {CNT_W{1'b0}};
      else
        EVENT_COUNT <= EVENT_COUNT + {{(CNT_W-IW){1'b0}}, nxt_inc};
    end
  end
endmodule // mesh_stop_event_select

// [mesh_stop_event_defines.vh]
// Event codes, unit-mask bit positions and widths for the mesh stop event selector.
// Assumes the includer uses these as plain constants; no logic lives here.
`ifndef MESH_STOP_EVENT_DEFINES_VH
`define MESH_STOP_EVENT_DEFINES_VH

`define EVT_INGRESS_OCCUPANCY 8'hB0
`define EVT_INGRESS_ALLOC 8'hB1
`define EVT_INGRESS_CREDIT_STARVE 8'hB3
`define EVT_REQ_AG0_STALL 8'hD0
`define EVT_REQ_AG1_STALL 8'hD2
`define EVT_DATA_AG0_STALL 8'hD4
`define EVT_DATA_AG1_STALL 8'hD6
`define EVT_HORIZ_ALLOC 8'h95
`define EVT_HORIZ_FULL 8'h96
`define EVT_HORIZ_NONEMPTY 8'h97
`define EVT_HORIZ_DEADLOCK_SLOT 8'h9D
`define EVT_HORIZ_BYPASS 8'h9F

// Unit-mask bit positions within bits 15:8 (bit 0 here is EVENT_SEL bit 8)
`define UM_REQ_BNC 0
`define UM_ACK_BNC 1
`define UM_DATA_BNC 2
`define UM_SNOOP_BNC 3
`define UM_REQ_CRD 4
`define UM_DATA_CRD 6
`define UM_EXTRA_ACK_CRD 7

// Class mask of bits present in the deadlock-slot event (no snoop bounce)
`define UM_DEADLOCK_SLOT_MASK 8'h57
`define UM_CLASS_MASK 8'h5F
`define UM_STARVE_MASK 8'hDF
`define UM_TRANSGRESS_MASK 8'h3F

`define NUM_CLASSES 8
`define NUM_TRANSGRESS 6
`define OCC_WIDTH 6
`define INC_WIDTH 9

`endif

// [class_accum.v]
// Qualified sum of per-class contributions under a unit-mask.
// Assumes the caller drives it from one REF_CLK domain; it holds no state itself.
`timescale 1ns/1ps
module class_accum #(
  parameter N = 8,
  parameter W = 6,
  parameter OW = 9
) (
  input wire [N*W-1:0] vals, // Per-class values, class 0 in low bits
  input wire [N-1:0] sel, // Enabled classes
  output reg [OW-1:0] sum, // Sum of enabled class values
  output reg any // Some enabled class has a nonzero value
);
  integer i;
  always @* begin
    sum = {OW{1'b0}};
    any = 1'b0;
    for (i = 0; i < N; i = i + 1) begin
      if (sel[i]) begin
        sum = sum + {{(OW-W){1'b0}}, vals[i*W +: W]};
        any = any | (|vals[i*W +: W]);
      end
    end
  end
endmodule // class_accum

// [mesh_stop_event_select_chk.sv]
// Checker for the mesh stop event selector, watching its ports only.
// Assumes one REF_CLK domain and a synchronous active-high SYS_RST.
`timescale 1ns/1ps
module mesh_stop_event_select_chk #(
  parameter CNT_W = 48
) (
  input wire REF_CLK, // Uncore clock
  input wire SYS_RST, // Sync reset
  input wire [15:0] EVENT_SEL, // Code and mask
  input wire [7:0] INGRESS_ALLOC, // Ingress allocations
  input wire [7:0] INGRESS_STARVE, // Starvation levels
  input wire [5:0] REQ_AG0_STALL, // Request agent0 stalls
  input wire [7:0] HORIZ_FULL, // Full levels
  input wire [7:0] HORIZ_NONEMPTY, // Not-empty levels
  input wire CNT_CLEAR, // Count clear
  input wire [CNT_W-1:0] EVENT_COUNT, // Count
  input wire [8:0] EVENT_INC, // Increment
  input wire EVENT_HIT // Hit flag
);
  reg live_ff;
  wire [7:0] m = EVENT_SEL[15:8];
  // Masks the first edge after reset, where $past still sees reset-time inputs
  always @(posedge REF_CLK) live_ff <= !SYS_RST;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  AST_HIT: assert property (EVENT_HIT == (EVENT_INC != 9'h000))
    else $error("hit flag disagrees with increment");
  AST_ACC: assert property (live_ff && !$past(CNT_CLEAR) |->
    EVENT_COUNT == $past(EVENT_COUNT) + EVENT_INC) else $error("count not accumulated");
  AST_CLR: assert property (live_ff && $past(CNT_CLEAR) |-> EVENT_COUNT == 0)
    else $error("clear did not zero count");
  AST_UNK: assert property (live_ff && $past(EVENT_SEL[7:0]) == 8'h00 |-> EVENT_INC == 0)
    else $error("unknown code counted");
  AST_ALLOC: assert property (live_ff && $past(EVENT_SEL[7:0]) == 8'hB1 |->
    EVENT_INC == $countones($past(INGRESS_ALLOC & m & 8'h5F))) else $error("alloc sum wrong");
  AST_STALL: assert property (live_ff && $past(EVENT_SEL[7:0]) == 8'hD0 |->
    EVENT_INC == $countones($past(REQ_AG0_STALL & m[5:0]))) else $error("stall count wrong");
  AST_STARVE: assert property (live_ff && $past(EVENT_SEL[7:0]) == 8'hB3 |->
    EVENT_INC == $past(|(INGRESS_STARVE & m & 8'hDF))) else $error("starve wrong");
  AST_FULL: assert property (live_ff && $past(EVENT_SEL[7:0]) == 8'h96 |->
    EVENT_INC == $past(|(HORIZ_FULL & m & 8'h5F))) else $error("full wrong");
  AST_NE: assert property (live_ff && $past(EVENT_SEL[7:0]) == 8'h97 |->
    EVENT_INC == $past(|(HORIZ_NONEMPTY & m & 8'h5F))) else $error("not-empty wrong");
endmodule // mesh_stop_event_select_chk
bind mesh_stop_event_select mesh_stop_event_select_chk #(.CNT_W(CNT_W)) u_chk (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .EVENT_SEL(EVENT_SEL), .INGRESS_ALLOC(INGRESS_ALLOC),
  .INGRESS_STARVE(INGRESS_STARVE), .REQ_AG0_STALL(REQ_AG0_STALL), .HORIZ_FULL(HORIZ_FULL),
  .HORIZ_NONEMPTY(HORIZ_NONEMPTY), .CNT_CLEAR(CNT_CLEAR), .EVENT_COUNT(EVENT_COUNT),
  .EVENT_INC(EVENT_INC), .EVENT_HIT(EVENT_HIT));

// [tb_top.sv]
// Self-checking bench for the mesh stop event selector.
// Assumes one-cycle latency from sampled inputs to EVENT_INC and EVENT_COUNT.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch at %0t got %0h exp %0h", $time, a, b); end end
module tb_top;
  reg REF_CLK = 0, SYS_RST = 1, CNT_CLEAR = 0;
  reg [15:0] EVENT_SEL = 16'h0000;
  reg [7:0] INGRESS_ALLOC = 8'h31, INGRESS_STARVE = 8'hA2, HORIZ_SLOT_USED = 8'h0C;
  reg [7:0] HORIZ_BYPASS = 8'h50, HORIZ_FULL = 8'h41, HORIZ_NONEMPTY = 8'h02;
  reg [7:0] HORIZ_ALLOC = 8'h09;
  reg [47:0] INGRESS_OCC = 48'h0000_0500_003F; // Class 0 = 63, class 4 = 5
  reg [5:0] REQ_AG0_STALL = 6'h3F, REQ_AG1_STALL = 6'h21, DATA_AG0_STALL = 6'h01;
  reg [5:0] DATA_AG1_STALL = 6'h20;
  wire [47:0] EVENT_COUNT;
  wire [8:0] EVENT_INC;
  wire EVENT_HIT;
  int err_count = 0, n_checks = 0, cyc = 0;
  logic [47:0] tot = 48'h0;
  mesh_stop_event_select u_mesh_stop_event_select (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
    .EVENT_SEL(EVENT_SEL), .INGRESS_ALLOC(INGRESS_ALLOC), .INGRESS_OCC(INGRESS_OCC),
    .INGRESS_STARVE(INGRESS_STARVE), .REQ_AG0_STALL(REQ_AG0_STALL),
    .REQ_AG1_STALL(REQ_AG1_STALL), .DATA_AG0_STALL(DATA_AG0_STALL),
    .DATA_AG1_STALL(DATA_AG1_STALL), .HORIZ_SLOT_USED(HORIZ_SLOT_USED),
    .HORIZ_BYPASS(HORIZ_BYPASS), .HORIZ_FULL(HORIZ_FULL), .HORIZ_NONEMPTY(HORIZ_NONEMPTY),
    .HORIZ_ALLOC(HORIZ_ALLOC), .CNT_CLEAR(CNT_CLEAR), .EVENT_COUNT(EVENT_COUNT),
    .EVENT_INC(EVENT_INC), .EVENT_HIT(EVENT_HIT));
  initial begin
    forever #4 REF_CLK = ~REF_CLK;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One selection for exactly one sampling edge, entered at a falling edge
  task ev(input [15:0] s, input [8:0] e);
    EVENT_SEL = s;
    @(posedge REF_CLK);
    #1 `CHK(EVENT_INC, e)
    `CHK(EVENT_HIT, (e != 9'h000))
    tot += e;
    @(negedge REF_CLK);
  endtask
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (2) @(negedge REF_CLK);
    SYS_RST = 0;
    CNT_CLEAR = 1;
    ev(16'h0000, 9'h000);
    CNT_CLEAR = 0;
    `CHK(EVENT_COUNT, 48'h0)
    ev(16'h01B1, 9'h001);
    ev(16'h11B1, 9'h002);
    ev(16'h20B1, 9'h000);
    ev(16'h11B0, 9'h044);
    ev(16'h82B3, 9'h001);
    ev(16'h80B3, 9'h001);
    ev(16'h20B3, 9'h000);
    $display("ingress test done");
    ev(16'h3FD0, 9'h006);
    ev(16'hC0D0, 9'h000);
    ev(16'h20D2, 9'h001);
    ev(16'h1ED2, 9'h000);
    ev(16'h3FD4, 9'h001);
    ev(16'h20D6, 9'h001);
    $display("stall test done");
    ev(16'h0C9D, 9'h001);
    ev(16'h509F, 9'h002);
    ev(16'h4196, 9'h001);
    ev(16'h0296, 9'h000);
    ev(16'h0297, 9'h001);
    ev(16'h0895, 9'h001);
    ev(16'h0995, 9'h002);
    ev(16'hFF00, 9'h000);
    `CHK(EVENT_COUNT, tot)
    $display("horizontal test done");
    SYS_RST = 1;
    ev(16'h11B1, 9'h000);
    SYS_RST = 0;
    tot = 48'h0;
    `CHK(EVENT_COUNT, 48'h0)
    ev(16'h11B1, 9'h002);
    `CHK(EVENT_COUNT, tot)
    $display("reset test done");
    report_and_stop;
  end
endmodule // tb_top
